/* File: rtl/ccrp_device.sv */
/*
 * Device end of the configuration CRC readout port: readout shift register,
 * precomputed and signature registers, periodic check engine and error flag.
 * Assumes the user end drives the readout clock enable, selects and
 * reconfiguration request over ccrp_if; one core clock at 100 MHz.
 */
// Operation
// - Load and shift only on readout clock edge
// - Select high shifts one bit per edge
// - Select low loads from chosen source
// - User holds select low two cycles
// - Source zero loads precomputed CRC register
// - Source one loads computed signature register
// - Source ignored while shifting
// - Error flag timed by oscillator, not readout
// - Flag high when computed CRC mismatches
// - Flag reaches core via enabled two-way pin
// - One bit per cycle, 31 more clocks
// - System pulses reconfig_request_n after error
// - Flag holds until clean next calculation
// - Check clock is oscillator over two-to-n
// - Precomputed register loaded before user mode
`timescale 1ns/1ps
`include "ccrp_cfg.svh"

module ccrp_device #(
    parameter int WORD_W = `CCRP_WORD_W,
    parameter int CHECK_LEN = `CCRP_CHECK_LEN
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Configuration image side
    input wire logic i_config_done,
    input wire logic [WORD_W-1:0] i_expected_sig,
    input wire logic i_cfg_bit,
    input wire logic [`CCRP_DIV_W-1:0] i_div_exp,
    // Link to the user end
    ccrp_if.dev link,
    // Status
    output logic o_user_mode,
    output logic o_check_done
);
    // ------------------------------------------------------------------------
    // Oscillator tick and check clock divider
    // ------------------------------------------------------------------------
    logic osc_tick_reg, osc_tick_next;
    logic [`CCRP_DIV_MAX-1:0] div_cnt_reg, div_cnt_next;
    logic chk_tick;
    logic [`CCRP_DIV_W-1:0] div_exp_lim;

    // Exponent beyond the valid range is clamped to the largest divisor
    assign div_exp_lim = (i_div_exp > `CCRP_DIV_W'(`CCRP_DIV_MAX)) ? `CCRP_DIV_W'(`CCRP_DIV_MAX) : i_div_exp;

    // Core clock over two stands in for the internal oscillator
    always_comb begin
        osc_tick_next = ~osc_tick_reg;
        div_cnt_next = div_cnt_reg;
        if (osc_tick_reg) begin
            div_cnt_next = div_cnt_reg + 1'b1;
        end
    end

    // Check enable fires once per 2^n oscillator ticks
    always_comb begin
        chk_tick = 1'b0;
        if (osc_tick_reg) begin
            if (div_exp_lim == '0) begin
                chk_tick = 1'b1;
            end else begin
                chk_tick = ((div_cnt_reg & ((`CCRP_DIV_MAX'(1) << div_exp_lim) - 1'b1))
                            == ((`CCRP_DIV_MAX'(1) << div_exp_lim) - 1'b1));
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            osc_tick_reg <= 1'b0;
            div_cnt_reg <= '0;
        end else begin
            osc_tick_reg <= osc_tick_next;
            div_cnt_reg <= div_cnt_next;
        end
    end

    // ------------------------------------------------------------------------
    // Precomputed register and user mode
    // ------------------------------------------------------------------------
    logic [WORD_W-1:0] precomp_reg, precomp_next;
    logic user_mode_reg, user_mode_next;

    // Expected signature captured when configuration ends
    always_comb begin
        precomp_next = precomp_reg;
        user_mode_next = user_mode_reg;
        if (i_config_done && !user_mode_reg) begin
            precomp_next = i_expected_sig;
            user_mode_next = 1'b1;
        end
        if (!link.reconfig_request_n) begin
            user_mode_next = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            precomp_reg <= '0;
            user_mode_reg <= 1'b0;
        end else begin
            precomp_reg <= precomp_next;
            user_mode_reg <= user_mode_next;
        end
    end

    // ------------------------------------------------------------------------
    // Check engine: serial CRC over the configuration bit stream
    // ------------------------------------------------------------------------
    localparam logic [WORD_W-1:0] POLY = `CCRP_CRC_POLY;
    logic [WORD_W-1:0] crc_reg, crc_next;
    logic [WORD_W-1:0] sig_reg, sig_next;
    logic [$clog2(CHECK_LEN)-1:0] bit_cnt_reg, bit_cnt_next;
    logic err_reg, err_next;
    logic done_reg, done_next;
    logic fb;

    // One stream bit per check tick; compare at the end of each pass
    always_comb begin
        fb = crc_reg[WORD_W-1] ^ i_cfg_bit;
        crc_next = crc_reg;
        sig_next = sig_reg;
        bit_cnt_next = bit_cnt_reg;
        err_next = err_reg;
        done_next = 1'b0;
        if (user_mode_reg && chk_tick) begin
            crc_next = {crc_reg[WORD_W-2:0], 1'b0} ^ (fb ? POLY : '0);
            bit_cnt_next = bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == ($clog2(CHECK_LEN))'(CHECK_LEN - 1)) begin
                sig_next = crc_next;
                err_next = (crc_next != precomp_reg);
                crc_next = '0;
                bit_cnt_next = '0;
                done_next = 1'b1;
            end
        end
    end

    // Flag updates only on oscillator-derived ticks
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            crc_reg <= '0;
            sig_reg <= '0;
            bit_cnt_reg <= '0;
            err_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            crc_reg <= crc_next;
            sig_reg <= sig_next;
            bit_cnt_reg <= bit_cnt_next;
            err_reg <= err_next;
            done_reg <= done_next;
        end
    end

    // ------------------------------------------------------------------------
    // Readout shift register
    // ------------------------------------------------------------------------
    logic [WORD_W-1:0] sr_reg, sr_next;

    // Load or shift on each readout clock rising edge
    always_comb begin
        sr_next = sr_reg;
        if (link.rd_clk_en) begin
            if (link.shift_nload) begin
                sr_next = {sr_reg[WORD_W-2:0], 1'b0};
            end else if (link.load_src) begin
                sr_next = sig_reg;
            end else begin
                sr_next = precomp_reg;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            sr_reg <= '0;
        end else begin
            sr_reg <= sr_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign link.serial_out = sr_reg[WORD_W-1];
    assign link.err_pin_o = err_reg;
    assign link.err_pin_oe = 1'b1;
    assign o_user_mode = user_mode_reg;
    assign o_check_done = done_reg;
endmodule : ccrp_device

/* File: rtl/ccrp_cfg.svh */
/*
 * Constants for the configuration CRC readout port: widths, divider range,
 * load-hold figure and check timing.
 * Assumes inclusion by its bare name from the package and design files.
 */
`ifndef CCRP_CFG_SVH
`define CCRP_CFG_SVH

// ----------------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------------
`define CCRP_WORD_W 32
`define CCRP_SHIFTS_AFTER_LOAD 31
`define CCRP_LOAD_HOLD_CYCLES 2
`define CCRP_DIV_MAX 8
`define CCRP_DIV_W 4
`define CCRP_CHECK_LEN 64
`define CCRP_OSC_DIV_RATIO 2
`define CCRP_RDCLK_DIV 4
`define CCRP_RECONF_PULSE_CYCLES 4
`define CCRP_CRC_POLY 32'h04c11db7

`endif

/* File: rtl/ccrp_pkg.sv */
/*
 * Types shared by the user end and the bench of the configuration CRC readout port.
 * Assumes ccrp_cfg.svh is on the include path.
 */
`include "ccrp_cfg.svh"

package ccrp_pkg;
    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef logic [`CCRP_WORD_W-1:0] ccrp_word_t;
    typedef enum logic {CCRP_SRC_PRECOMP, CCRP_SRC_SIGNATURE} ccrp_src_t;
    typedef enum {CCRP_U_IDLE, CCRP_U_LOAD, CCRP_U_SHIFT, CCRP_U_DONE} ccrp_user_st_t;
endpackage : ccrp_pkg

/* File: rtl/ccrp_if.sv */
/*
 * Carrier between the CRC readout port and the user logic.
 * The error flag reaches the core through a two-way pin; the wire level is
 * resolved here from the enable.
 */
`timescale 1ns/1ps

interface ccrp_if;
    logic rd_clk_en;
    logic shift_nload;
    logic load_src;
    logic serial_out;
    logic err_pin_o;
    logic err_pin_oe;
    logic err_pin_i;
    logic reconfig_request_n;

    // Two-way pin level, pulled low when nobody drives it
    assign err_pin_i = err_pin_oe ? err_pin_o : 1'b0;

    modport dev (input rd_clk_en, input shift_nload, input load_src, input reconfig_request_n,
                 output serial_out, output err_pin_o, output err_pin_oe);
    modport usr (output rd_clk_en, output shift_nload, output load_src, output reconfig_request_n,
                 input serial_out, input err_pin_i);
endinterface : ccrp_if

/* File: rtl/ccrp_user.sv */
/*
 * User end of the configuration CRC readout port: drives the readout clock,
 * load and shift selects, gathers 32 bits, and requests reconfiguration
 * after the error flag is seen.
 * Assumes the device end over ccrp_if, one core clock.
 */
`timescale 1ns/1ps
`include "ccrp_cfg.svh"

module ccrp_user #(
    parameter int WORD_W = `CCRP_WORD_W,
    parameter int RDCLK_DIV = `CCRP_RDCLK_DIV
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Read request
    input wire logic i_rd_start,
    input wire logic i_rd_src,
    output logic o_rd_busy,
    output logic o_rd_valid,
    output logic [WORD_W-1:0] o_rd_data,
    // Error handling
    input wire logic i_safe_to_reconf,
    output logic o_err_seen,
    // Link to the device end
    ccrp_if.usr link
);
    // ------------------------------------------------------------------------
    // Readout clock divider
    // ------------------------------------------------------------------------
    logic [$clog2(RDCLK_DIV+1)-1:0] div_reg, div_next;
    logic tick;

    always_comb begin
        tick = (div_reg == ($clog2(RDCLK_DIV+1))'(RDCLK_DIV - 1));
        div_next = tick ? '0 : div_reg + 1'b1;
    end

    // ------------------------------------------------------------------------
    // Readout sequencer
    // ------------------------------------------------------------------------
    ccrp_pkg::ccrp_user_st_t st_reg, st_next;
    logic [5:0] cnt_reg, cnt_next;
    logic src_reg, src_next;
    logic [WORD_W-1:0] data_reg, data_next;
    logic valid_reg, valid_next;

    // Load held two edges, then first bit taken and 31 shifts
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        src_next = src_reg;
        data_next = data_reg;
        valid_next = 1'b0;
        case (st_reg)
            ccrp_pkg::CCRP_U_IDLE: begin
                if (i_rd_start) begin
                    src_next = i_rd_src;
                    cnt_next = '0;
                    st_next = ccrp_pkg::CCRP_U_LOAD;
                end
            end
            ccrp_pkg::CCRP_U_LOAD: begin
                if (tick) begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == 6'(`CCRP_LOAD_HOLD_CYCLES - 1)) begin
                        cnt_next = '0;
                        st_next = ccrp_pkg::CCRP_U_SHIFT;
                    end
                end
            end
            ccrp_pkg::CCRP_U_SHIFT: begin
                if (tick) begin
                    data_next = {data_reg[WORD_W-2:0], link.serial_out};
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == 6'(`CCRP_SHIFTS_AFTER_LOAD)) begin
                        st_next = ccrp_pkg::CCRP_U_DONE;
                    end
                end
            end
            ccrp_pkg::CCRP_U_DONE: begin
                valid_next = 1'b1;
                st_next = ccrp_pkg::CCRP_U_IDLE;
            end
            default: st_next = ccrp_pkg::CCRP_U_IDLE;
        endcase
    end

    // ------------------------------------------------------------------------
    // Error pin synchroniser and reconfiguration pulse
    // ------------------------------------------------------------------------
    logic err_s1_reg, err_s2_reg;
    logic seen_reg, seen_next;
    logic [2:0] pulse_reg, pulse_next;

    // Sticky seen flag; pulse request low once safe
    always_comb begin
        seen_next = seen_reg | err_s2_reg;
        pulse_next = pulse_reg;
        if (pulse_reg != '0) begin
            pulse_next = pulse_reg - 1'b1;
        end else if (seen_reg && i_safe_to_reconf) begin
            pulse_next = 3'(`CCRP_RECONF_PULSE_CYCLES);
            seen_next = err_s2_reg;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            div_reg <= '0;
            st_reg <= ccrp_pkg::CCRP_U_IDLE;
            cnt_reg <= '0;
            src_reg <= 1'b0;
            data_reg <= '0;
            valid_reg <= 1'b0;
            err_s1_reg <= 1'b0;
            err_s2_reg <= 1'b0;
            seen_reg <= 1'b0;
            pulse_reg <= '0;
        end else begin
            div_reg <= div_next;
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            src_reg <= src_next;
            data_reg <= data_next;
            valid_reg <= valid_next;
            err_s1_reg <= link.err_pin_i;
            err_s2_reg <= err_s1_reg;
            seen_reg <= seen_next;
            pulse_reg <= pulse_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign link.rd_clk_en = tick && (st_reg == ccrp_pkg::CCRP_U_LOAD || (st_reg == ccrp_pkg::CCRP_U_SHIFT
                            && cnt_reg != 6'(`CCRP_SHIFTS_AFTER_LOAD)));
    assign link.shift_nload = (st_reg == ccrp_pkg::CCRP_U_SHIFT);
    assign link.load_src = src_reg;
    assign link.reconfig_request_n = (pulse_reg == '0);
    assign o_rd_busy = (st_reg != ccrp_pkg::CCRP_U_IDLE);
    assign o_rd_valid = valid_reg;
    assign o_rd_data = data_reg;
    assign o_err_seen = seen_reg;
endmodule : ccrp_user

/* File: tb/ccrp_link_chk.sv */
/* Checker for the readout link between the device end and the user end.
   Assumes tb instantiates it beside the ccrp_if instance, one core clock. */
`timescale 1ns/1ps

module ccrp_link_chk (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Link signals
    input wire logic rd_clk_en,
    input wire logic shift_nload,
    input wire logic serial_out,
    input wire logic err_pin_o,
    input wire logic err_pin_oe,
    input wire logic reconfig_request_n
);
    logic [5:0] shift_cnt_reg;
    logic [5:0] shift_cnt_next;
    logic [1:0] load_cnt_reg;
    logic [1:0] load_cnt_next;
    logic err_any_reg;
    logic err_any_next;

    // ------------------------------------------------------------------------
    // Shift edges since the last load, load edges since the last shift, and error history
    // ------------------------------------------------------------------------
    always_comb begin
        shift_cnt_next = shift_cnt_reg;
        load_cnt_next = load_cnt_reg;
        err_any_next = err_any_reg | err_pin_o;
        if (rd_clk_en && shift_nload) begin
            shift_cnt_next = shift_cnt_reg + 6'h1;
            load_cnt_next = 2'h0;
        end
        if (rd_clk_en && !shift_nload) begin
            shift_cnt_next = 6'h0;
            load_cnt_next = (load_cnt_reg == 2'h3) ? load_cnt_reg : load_cnt_reg + 2'h1;
        end
    end

    // Register the helper state
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            shift_cnt_reg <= 6'h0;
            load_cnt_reg <= 2'h0;
            err_any_reg <= 1'b0;
        end else begin
            shift_cnt_reg <= shift_cnt_next;
            load_cnt_reg <= load_cnt_next;
            err_any_reg <= err_any_next;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    a_move_on_edge: assert property (!rd_clk_en |=> $stable(serial_out))
        else $error("serial output moved without a readout edge");
    a_edge_spacing: assert property (rd_clk_en |=> !rd_clk_en [*3])
        else $error("readout edges closer than four cycles");
    a_load_hold: assert property ($fell(shift_nload) |-> !shift_nload [*2])
        else $error("load select low for under two cycles");
    a_load_pair: assert property (rd_clk_en && shift_nload && shift_cnt_reg == 6'h0 |-> load_cnt_reg >= 2'h2)
        else $error("shifting began after fewer than two load edges");
    a_shift_bound: assert property (rd_clk_en && shift_nload |-> shift_cnt_reg < 6'd31)
        else $error("more than 31 shift edges after a load");
    a_shift_full: assert property (rd_clk_en && !shift_nload && shift_cnt_reg != 6'h0 |-> shift_cnt_reg == 6'd31)
        else $error("readout cut short before 31 shifts");
    a_oe_tied: assert property (err_pin_oe)
        else $error("error pin output enable dropped");
    a_reconf_pulse: assert property ($fell(reconfig_request_n) |-> !reconfig_request_n [*4] ##1 reconfig_request_n)
        else $error("reconfiguration pulse not four cycles");
    a_reconf_cause: assert property ($fell(reconfig_request_n) |-> err_any_reg)
        else $error("reconfiguration requested with no error seen");
endmodule : ccrp_link_chk

/* File: tb/tb.sv */
/* Self-checking bench joining both ends of the readout port.
   Assumes ccrp_pkg and ccrp_cfg.svh are compiled and on the include path. */
`timescale 1ns/1ps
`include "ccrp_cfg.svh"

module tb;
    localparam int CHECK_LEN = 8;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_config_done = 1'b0;
    ccrp_pkg::ccrp_word_t i_expected_sig = 32'h0;
    logic i_cfg_bit = 1'b1;
    logic [`CCRP_DIV_W-1:0] i_div_exp = 4'h0;
    logic i_rd_start = 1'b0;
    logic i_rd_src = 1'b0;
    logic i_safe_to_reconf = 1'b0;
    logic o_user_mode, o_check_done, o_rd_busy, o_rd_valid, o_err_seen;
    ccrp_pkg::ccrp_word_t o_rd_data;
    logic [31:0] lfsr = 32'haa4f;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_ld = 0;
    int n_sh = 0;
    logic [3:0] divs [5] = '{4'h0, 4'h1, 4'h3, 4'h8, 4'hf};

    // ------------------------------------------------------------------------
    // Clock, link and both ends
    // ------------------------------------------------------------------------
    always #5 i_core_clk = ~i_core_clk;

    ccrp_if link_if();
    ccrp_device #(.CHECK_LEN(CHECK_LEN)) i_ccrp_device (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_config_done(i_config_done), .i_expected_sig(i_expected_sig), .i_cfg_bit(i_cfg_bit),
        .i_div_exp(i_div_exp), .link(link_if), .o_user_mode(o_user_mode), .o_check_done(o_check_done));
    ccrp_user i_ccrp_user (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_rd_start(i_rd_start),
        .i_rd_src(i_rd_src), .o_rd_busy(o_rd_busy), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
        .i_safe_to_reconf(i_safe_to_reconf), .o_err_seen(o_err_seen), .link(link_if));
    ccrp_link_chk i_ccrp_link_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .rd_clk_en(link_if.rd_clk_en),
        .shift_nload(link_if.shift_nload), .serial_out(link_if.serial_out), .err_pin_o(link_if.err_pin_o),
        .err_pin_oe(link_if.err_pin_oe), .reconfig_request_n(link_if.reconfig_request_n));

    // Count load and shift edges on the wire
    always @(posedge i_core_clk) begin
        if (link_if.rd_clk_en === 1'b1 && link_if.shift_nload === 1'b1) n_sh++;
        if (link_if.rd_clk_en === 1'b1 && link_if.shift_nload === 1'b0) n_ld++;
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] next_rand();
        lfsr = (lfsr >> 1) ^ (lfsr[0] ? 32'h80200003 : 32'h0);
        return lfsr;
    endfunction : next_rand

    // Cycles between pass ends: oscillator is half the core rate
    function automatic int exp_period(input int n);
        return CHECK_LEN * 2 * (1 << ((n > 8) ? 8 : n));
    endfunction : exp_period

    // Stored signature: serial CRC of one pass of a constant stream bit
    function automatic logic [31:0] exp_sig(input logic bit_in);
        logic [31:0] c;
        c = 32'h0;
        for (int k = 0; k < CHECK_LEN; k++) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ bit_in) ? `CCRP_CRC_POLY : 32'h0);
        end
        return c;
    endfunction : exp_sig

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {31'h0, exp}, {31'h0, got});
    endtask : chk_bit

    task automatic wait_pass(output int cyc);
        cyc = 0;
        do begin
            @(posedge i_core_clk);
            cyc++;
        end while (o_check_done !== 1'b1 && cyc < 5000);
        chk_bit("pass end", 1'b1, o_check_done);
    endtask : wait_pass

    task automatic wait_mode(input logic lvl);
        for (int k = 0; k < 60 && o_user_mode !== lvl; k++) @(posedge i_core_clk);
    endtask : wait_mode

    // One full readout; edges are counted on the wire
    task automatic do_read(input logic src, output logic [31:0] data);
        int k;
        n_ld = 0;
        n_sh = 0;
        @(posedge i_core_clk);
        i_rd_start <= 1'b1;
        i_rd_src <= src;
        for (k = 0; k < 20 && o_rd_busy !== 1'b1; k++) @(posedge i_core_clk);
        chk_bit("read busy", 1'b1, o_rd_busy);
        i_rd_start <= 1'b0;
        for (k = 0; k < 400 && o_rd_valid !== 1'b1; k++) @(posedge i_core_clk);
        chk_bit("read valid", 1'b1, o_rd_valid);
        data = o_rd_data;
        chk_word("load edges", 32'd2, n_ld);
        chk_word("shift edges", 32'd31, n_sh);
    endtask : do_read

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [31:0] e1;
        logic [31:0] sig;
        logic [31:0] got;
        int cyc;
        repeat (10) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        e1 = next_rand();
        i_expected_sig <= e1;
        i_config_done <= 1'b1;
        wait_mode(1'b1);
        chk_bit("user mode", 1'b1, o_user_mode);
        for (int i = 0; i < 3; i++) begin
            do_read(1'b0, got);
            chk_word("precomputed read", e1, got);
        end
        // Divider sweep, random stored word gives a lasting error
        foreach (divs[i]) begin
            i_div_exp <= divs[i];
            wait_pass(cyc);
            wait_pass(cyc);
            wait_pass(cyc);
            chk_word("pass period", exp_period(divs[i]), cyc);
            chk_bit("error flag", 1'b1, link_if.err_pin_i);
        end
        i_div_exp <= 4'h0;
        chk_bit("error seen", 1'b1, o_err_seen);
        chk_bit("no early reconfig", 1'b1, link_if.reconfig_request_n);
        do_read(1'b1, sig);
        chk_word("signature value", exp_sig(i_cfg_bit), sig);
        do_read(1'b0, got);
        chk_word("source switch", e1, got);
        // Reconfigure with the signature as the stored word
        i_config_done <= 1'b0;
        i_safe_to_reconf <= 1'b1;
        wait_mode(1'b0);
        chk_bit("user mode left", 1'b0, o_user_mode);
        i_safe_to_reconf <= 1'b0;
        i_expected_sig <= sig;
        i_config_done <= 1'b1;
        wait_mode(1'b1);
        chk_bit("user mode back", 1'b1, o_user_mode);
        do_read(1'b0, got);
        chk_word("reloaded word", sig, got);
        wait_pass(cyc);
        wait_pass(cyc);
        chk_bit("clean flag", 1'b0, link_if.err_pin_i);
        do_read(1'b1, got);
        chk_word("signature read", sig, got);
        print_verdict();
    end

    // Watchdog at about twice the expected run of some 30000 cycles
    initial begin
        #600000;
        n_mismatch++;
        print_verdict();
    end
endmodule : tb
